// [rtl/phy_clock_source_select.sv]
/*
 * Clock source handling of the dual-speed PHY: 25 MHz output from the
 * 50 MHz oscillator, crystal tie-high detection, divide-by-2.5 fallback
 * and the 10 Mb/s clock selection.  All clock pins are sampled by clk.
 * Assumes the oscillator pin toggles whenever this block runs.
 */
//
// Functional notes
// - Output 25 MHz by halving the oscillator.
// - Config bit 7 set stops 25 MHz output.
// - Resets never disturb the 25 MHz output.
// - Crystal tied high selects 50/2.5 derived clock.
// - Driven crystal clocks 10BASE-T and autonegotiation.
// - Accept 25 MHz reference from any source.
`timescale 1ns/1ps

module phy_clock_source_select #(
  parameter int unsigned TIED_CYC = phy_clock_source_select_pkg::TIED_HIGH_CYC
) (
  input  wire logic                                       clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       osc50_in,
  input  wire logic                                       xtal20_in,
  input  wire logic                                       ref25_in,
  input  wire logic [15:0]                                pcsConfig,
  output logic                                            clk25_out,
  output logic                                            clk25Oe,
  output logic                                            xtal20_out,
  output logic                                            ref25Sampled,
  output phy_clock_source_select_pkg::clk10_status_t      clk10Status,
  output logic                                            tenLogicRst_n
);

  logic                                     oscMeta_ff;
  logic                                     oscSync_ff;
  logic                                     oscPrev_ff;
  logic                                     xtalMeta_ff;
  logic                                     xtalSync_ff;
  logic                                     refMeta_ff;
  logic                                     refSync_ff;
  // Power-up value only: the divider has no reset, so it needs a resolved start.
  logic                                     clk25_ff = 1'b0;
  logic                                     clk25Oe_ff;
  logic [2:0]                               phase_ff;
  logic                                     derived_ff;
  logic [phy_clock_source_select_pkg::TIED_CNT_W-1:0] highCnt_ff;
  logic                                     tied_ff;
  phy_clock_source_select_pkg::clk_src_t    src_ff;
  logic                                     srcLocked_ff;
  logic                                     clk10_ff;
  logic                                     release_ff;
  logic                                     oscRise;
  logic                                     oscFall;

  logic                                     riseToggle;
  logic                                     fallToggle;

  logic                                     tiedDecide;
  logic                                     xtalDecide;
  logic [phy_clock_source_select_pkg::TIED_CNT_W-1:0] tiedLimit;

  assign oscRise    = oscSync_ff & ~oscPrev_ff;
  assign oscFall    = ~oscSync_ff & oscPrev_ff;
  assign tiedLimit  = phy_clock_source_select_pkg::TIED_CNT_W'(TIED_CYC);

  // Two 20 MHz periods per five oscillator periods: toggles at rises 0 and 4
  // and at the falls after rises 1 and 2, that is at 0, 30, 50 and 80 ns.
  assign riseToggle = (phase_ff == 3'h0) ||
                      (phase_ff == phy_clock_source_select_pkg::DIV25_EDGES - 3'h1);
  assign fallToggle = (phase_ff == phy_clock_source_select_pkg::DIV25_HALF) ||
                      (phase_ff == phy_clock_source_select_pkg::DIV25_HALF + 3'h1);

  // The crystal wins only once the derived clock has run, so osc50_in is known alive.
  assign tiedDecide = tied_ff;
  assign xtalDecide = !xtalSync_ff && highCnt_ff == '0 && derived_ff;

  // The oscillator synchroniser has no reset: the 25 MHz output must keep
  // running through every reset, so nothing on its path may be cleared.
  always_ff @(posedge clk) begin
    oscMeta_ff <= osc50_in;
    oscSync_ff <= oscMeta_ff;
    oscPrev_ff <= oscSync_ff;
  end

  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtalMeta_ff <= 1'b0;
      xtalSync_ff <= 1'b0;
      refMeta_ff  <= 1'b0;
      refSync_ff  <= 1'b0;
    end else begin
      xtalMeta_ff <= xtal20_in;
      xtalSync_ff <= xtalMeta_ff;
      refMeta_ff  <= ref25_in;
      refSync_ff  <= refMeta_ff;
    end
  end

  // The divider deliberately has no reset, so chip resets cannot stop or re-phase it.
  always_ff @(posedge clk) begin
    if (oscRise) begin
      clk25_ff <= ~clk25_ff;
    end
  end

  // The output enable is a pure function of the config bit, so reset leaves it alone.
  always_ff @(posedge clk) begin
    clk25Oe_ff <= ~pcsConfig[phy_clock_source_select_pkg::CFG_CLK25_OFF_BIT];
  end

  // Divide-by-2.5 on both oscillator edges; duty is 30/20 ns, which the
  // 10 Mb/s logic tolerates, traded for needing no faster clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff   <= 3'h0;
      derived_ff <= 1'b0;
    end else if (oscRise) begin
      phase_ff <= (phase_ff == phy_clock_source_select_pkg::DIV25_EDGES - 3'h1)
                  ? 3'h0 : phase_ff + 3'h1;
      if (riseToggle) begin
        derived_ff <= ~derived_ff;
      end
    end else if (oscFall && fallToggle) begin
      derived_ff <= ~derived_ff;
    end
  end

  // A crystal that stays high for the whole window is taken as tied high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      highCnt_ff <= '0;
      tied_ff    <= 1'b0;
    end else if (!xtalSync_ff) begin
      highCnt_ff <= '0;
      tied_ff    <= 1'b0;
    end else if (highCnt_ff != tiedLimit) begin
      highCnt_ff <= highCnt_ff + 1'b1;
    end else begin
      tied_ff <= 1'b1;
    end
  end

  // Source is decided once after reset: derived once the detector has seen a full window,
  // crystal at the first low pin after the derived clock ran; choosing only once avoids a runtime switch glitching the clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff       <= phy_clock_source_select_pkg::SRC_XTAL;
      srcLocked_ff <= 1'b0;
    end else if (!srcLocked_ff) begin
      if (tiedDecide) begin
        src_ff       <= phy_clock_source_select_pkg::SRC_DERIVED;
        srcLocked_ff <= 1'b1;
      end else if (xtalDecide) begin
        src_ff       <= phy_clock_source_select_pkg::SRC_XTAL;
        srcLocked_ff <= 1'b1;
      end
    end
  end

  // Selected 10 Mb/s clock, gated low until the source is locked.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk10_ff <= 1'b0;
    end else if (!srcLocked_ff) begin
      clk10_ff <= 1'b0;
    end else if (src_ff == phy_clock_source_select_pkg::SRC_DERIVED) begin
      clk10_ff <= derived_ff;
    end else begin
      clk10_ff <= xtalSync_ff;
    end
  end

  // The 10 Mb/s and negotiation logic leaves reset only after the lock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      release_ff <= 1'b0;
    end else begin
      release_ff <= srcLocked_ff;
    end
  end

  // Crystal drive output follows the inverted input, as an oscillator stage would.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal20_out <= 1'b0;
    end else begin
      xtal20_out <= ~xtalSync_ff;
    end
  end

  assign clk25_out                = clk25_ff;
  assign clk25Oe                  = clk25Oe_ff;
  assign ref25Sampled             = refSync_ff;
  assign clk10Status.clk10Out     = clk10_ff;
  assign clk10Status.clk10Valid   = release_ff;
  assign clk10Status.src          = src_ff;
  assign tenLogicRst_n            = release_ff;

endmodule

// [rtl/phy_clock_source_select_pkg.sv]
/*
 * Package for the PHY clock source selection block: timing counts, the
 * clock-source enumeration and the grouped status carried out of the block.
 * Assumes a single 250 MHz system clock that samples all clock pins.
 */
package phy_clock_source_select_pkg;

  // System clock rate and the rates of the sampled clock pins.
  localparam int unsigned SYS_CLK_MHZ       = 250;
  localparam int unsigned OSC50_MHZ         = 50;
  localparam int unsigned XTAL20_MHZ        = 20;

  // Phase counter for the divide-by-2.5: two 20 MHz periods span five 50 MHz rising edges.
  localparam logic [2:0]  DIV25_EDGES       = 3'h5;
  localparam logic [2:0]  DIV25_HALF        = 3'h2;

  // Time the crystal pin must sit high before it counts as tied high, in ns.
  localparam int unsigned TIED_HIGH_NS      = 1000;
  localparam int unsigned TIED_HIGH_CYC     = (TIED_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned TIED_CNT_W        = 9;

  // Configuration bit that shuts off the 25 MHz output.
  localparam int unsigned CFG_CLK25_OFF_BIT = 7;
  localparam logic        CLK25_OFF_RST     = 1'b0;

  typedef enum logic {
    SRC_XTAL,
    SRC_DERIVED
  } clk_src_t;

  typedef struct packed {
    logic     clk10Out;
    logic     clk10Valid;
    clk_src_t src;
  } clk10_status_t;

endpackage

// [tb/board_clock_model.sv]
/* Board clocks: 50 MHz oscillator, 20 MHz crystal or pull-up, reference loop.
   Assumes the bench picks the crystal wiring before each reset. */
`timescale 1ns/1ps
module board_clock_model (
  input  wire logic tieHigh,
  input  wire logic clk25Loop,
  output logic      osc50,
  output logic      xtal20,
  output logic      ref25
);
  logic xtalRun;
  // The odd offset keeps osc50 edges off the sampling clock edges; every fourth xtal20 edge lands on a rising clk edge.
  initial begin
    osc50 = 1'b0;
    #1;
    forever #10 osc50 = ~osc50;
  end
  initial begin
    xtalRun = 1'b0;
    #3;
    forever #25 xtalRun = ~xtalRun;
  end
  assign xtal20 = tieHigh ? 1'b1 : xtalRun;
  assign ref25  = clk25Loop;
endmodule

// [tb/phy_clock_source_select_checker.sv]
/* Port checker for the clock source block.
   Assumes every pin is sampled by clk and osc50_in keeps running. */
`timescale 1ns/1ps
module phy_clock_source_select_checker #(
  parameter int unsigned TIED_CYC = 8
) (
  input wire logic                                       clk,
  input wire logic                                       rst_n,
  input wire logic                                       osc50_in,
  input wire logic                                       xtal20_in,
  input wire logic                                       ref25_in,
  input wire logic [15:0]                                pcsConfig,
  input wire logic                                       clk25_out,
  input wire logic                                       clk25Oe,
  input wire logic                                       xtal20_out,
  input wire logic                                       ref25Sampled,
  input wire phy_clock_source_select_pkg::clk10_status_t clk10Status,
  input wire logic                                       tenLogicRst_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_oe; clk25Oe != $past(pcsConfig[7]); endproperty
  a_oe: assert property (p_oe) else $error("clk25Oe off its config bit");
  property p_tog; $rose(osc50_in) |-> ##[1:4] $changed(clk25_out); endproperty
  a_tog: assert property (p_tog) else $error("clk25_out missed an edge");
  property p_hold; $changed(clk25_out) |=> $stable(clk25_out)[*3]; endproperty
  a_hold: assert property (p_hold) else $error("clk25_out too fast");
  property p_ref; $rose(ref25_in) |-> ##[1:3] ref25Sampled; endproperty
  a_ref: assert property (p_ref) else $error("reference not sampled");
  property p_lock; clk10Status.clk10Valid |=> clk10Status.clk10Valid && $stable(clk10Status.src);
  endproperty
  a_lock: assert property (p_lock) else $error("source changed after lock");
  property p_rel; !tenLogicRst_n |-> !clk10Status.clk10Out; endproperty
  a_rel: assert property (p_rel) else $error("10M clock ran before release");
  property p_xtal;
    clk10Status.clk10Valid && clk10Status.src == phy_clock_source_select_pkg::SRC_XTAL
      && $rose(xtal20_in) |-> ##[1:5] $rose(clk10Status.clk10Out);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal edge lost");
  c_der: cover property (clk10Status.src == phy_clock_source_select_pkg::SRC_DERIVED);
  c_xtal: cover property (clk10Status.clk10Valid && !clk10Status.src);
  c_off: cover property ($fell(clk25Oe));
endmodule
bind phy_clock_source_select phy_clock_source_select_checker #(.TIED_CYC(TIED_CYC)) chk (.*);

// [tb/tb_top.sv]
/* Bench for the clock source block.
   Assumes TIED_CYC of 8 and the board model on the pins. */
`timescale 1ns/1ps
module tb_top;
  logic                                       clk = 1'b0;
  logic                                       rst_n = 1'b0;
  logic                                       tieHigh = 1'b0;
  logic [15:0]                                pcsConfig = 16'h0000;
  logic                                       osc, xtal, ref25, clk25, oe, xout, refS, tenRst_n;
  phy_clock_source_select_pkg::clk10_status_t st;
  int                                         fail_count = 0;
  int                                         checked = 0;
  int                                         cycles = 0;
  always #2 clk = ~clk;
  board_clock_model brd (.tieHigh(tieHigh), .clk25Loop(clk25), .osc50(osc), .xtal20(xtal),
    .ref25(ref25));
  phy_clock_source_select #(.TIED_CYC(8)) dut (.clk(clk), .rst_n(rst_n), .osc50_in(osc),
    .xtal20_in(xtal), .ref25_in(ref25), .pcsConfig(pcsConfig), .clk25_out(clk25),
    .clk25Oe(oe), .xtal20_out(xout), .ref25Sampled(refS), .clk10Status(st),
    .tenLogicRst_n(tenRst_n));
  task automatic finish_test();
    $display("checked=%0d fails=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts clk25 changes and clk10 rises; sampled mid-cycle so edges have settled.
  task automatic count(input int cyc, output int c25, output int c10);
    logic p25, p10;
    c25 = 0;
    c10 = 0;
    @(negedge clk);
    {p25, p10} = {clk25, st.clk10Out};
    repeat (cyc) begin
      @(negedge clk);
      c25 += int'(clk25 !== p25);
      c10 += int'(st.clk10Out === 1'b1 && p10 === 1'b0);
      {p25, p10} = {clk25, st.clk10Out};
    end
  endtask
  task automatic t_src(input logic tie, input logic [15:0] exp);
    int c25, c10;
    @(posedge clk) tieHigh <= tie;
    rst_n <= 1'b0;
    count(100, c25, c10);
    cmp(16'(c25 >= 19 && c25 <= 21), 16'h0001);
    cmp({tenRst_n, st.clk10Valid}, 16'h0000);
    @(posedge clk) rst_n <= 1'b1;
    for (int i = 0; i < 300 && tenRst_n !== 1'b1; i++) @(posedge clk);
    cmp({st.clk10Valid, tenRst_n}, 16'h0003);
    cmp(st.src, exp);
    count(1000, c25, c10);
    cmp(16'(c10 >= 78 && c10 <= 82), 16'h0001);
    cmp(16'(c25 >= 198 && c25 <= 202), 16'h0001);
    if (tie) cmp(xout, 16'h0000);
    @(posedge clk) tieHigh <= !tie;
    count(100, c25, c10);
    cmp(st.src, exp);
    $display("source test done, tie=%0b", tie);
  endtask
  task automatic t_off();
    @(posedge clk) pcsConfig <= 16'hff7f;
    repeat (2) @(posedge clk);
    cmp(oe, 16'h0001);
    pcsConfig <= 16'h0080;
    repeat (2) @(posedge clk);
    cmp(oe, 16'h0000);
    pcsConfig <= 16'h0000;
    repeat (2) @(posedge clk);
    cmp(oe, 16'h0001);
    @(clk25);
    repeat (3) @(negedge clk);
    cmp(refS, clk25);
    $display("output shut-off test done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_off();
    t_src(1'b0, 16'h0000);
    t_src(1'b1, 16'h0001);
    finish_test();
  end
endmodule
